// ==== dma_channel_ctrl.sv ====
// dma channel control: three control registers, request logic and transfer sequencer
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module dma_channel_ctrl (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // peripheral and arbiter side
    input wire logic trigger_i,
    input wire logic swap_mode_i,
    input wire logic [2:0] current_priority_level_i,
    input wire logic ack_i,
    input wire logic [7:0] periph_data_i,
    input wire logic periph_to_mem_i,
    output logic dma_req_o,
    output logic eob_irq_o,
    output logic [2:0] source_priority_o,
    // register file / memory port
    output dma_channel_pkg::mem_req_t mem_req_o,
    input wire logic mem_ready_i,
    input wire logic [7:0] mem_rdata_i,
    input wire dma_channel_pkg::descriptor_t desc_i,
    output logic [7:0] desc_ptr_o,
    output logic [7:0] addr_ptr_o,
    output logic desc_wr_o,
    output dma_channel_pkg::descriptor_t desc_wdata_o,
    // byte toward the peripheral data register, two-entry buffer
    output logic [7:0] periph_data_o,
    output logic periph_valid_o,
    input wire logic periph_ready_i
);
    logic [7:0] counter_pointer;
    logic [7:0] request_control;
    logic [7:0] address_pointer;
    logic wr_pending;
    logic [7:0] wr_addr;
    logic bus_write;
    logic bus_read;
    logic pending;
    logic request_mask;
    logic eob_pending;
    dma_channel_pkg::xfer_state_t state;
    dma_channel_pkg::descriptor_t desc;
    logic [4:0] cycle_count;
    logic [4:0] cycle_target;
    logic [7:0] move_byte;
    logic serviced;
    logic counter_zero;
    // two-entry buffer
    logic [7:0] buf_data [0:1];
    logic [1:0] buf_count;
    logic buf_wr_ptr;
    logic buf_rd_ptr;
    logic buf_push;
    logic buf_pop;
    logic buf_ready;
    logic [7:0] next_request_control;
    logic [1:0] next_buf_count;
    logic next_rd_ptr;

    assign bus_write = hsel_i && hready_i && htrans_i[1] && hwrite_i;
    assign bus_read = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    assign pending = request_control[dma_channel_pkg::pending_bit];
    assign request_mask = request_control[dma_channel_pkg::request_mask_bit];
    assign buf_ready = buf_count != 2'd2;
    assign buf_pop = periph_valid_o && periph_ready_i;
    assign counter_zero = desc.count == 16'h0001;

    // ahb data phase tracking; zero wait states, always okay
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            wr_pending <= 1'b0;
            wr_addr <= 8'h00;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            wr_pending <= bus_write;
            if (bus_write) begin
                wr_addr <= haddr_i[7:0];
            end
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (bus_read) begin
            unique case (haddr_i[7:0])
                dma_channel_pkg::counter_pointer_addr: hrdata_o <= {24'h000000, counter_pointer};
                dma_channel_pkg::request_control_addr: hrdata_o <= {24'h000000, request_control};
                dma_channel_pkg::address_pointer_addr: hrdata_o <= {24'h000000, address_pointer};
                dma_channel_pkg::status_addr: hrdata_o <= {24'h000000, 5'h00, eob_pending, state};
                default: hrdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // pointer registers
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            counter_pointer <= dma_channel_pkg::counter_pointer_reset;
            address_pointer <= dma_channel_pkg::address_pointer_reset;
        end else if (wr_pending) begin
            if (wr_addr == dma_channel_pkg::counter_pointer_addr) begin
                counter_pointer <= hwdata_i[7:0];
            end
            if (wr_addr == dma_channel_pkg::address_pointer_addr) begin
                address_pointer <= hwdata_i[7:0];
            end
        end
    end

    // control register: software write, then hardware events on top, trigger last so it wins
    always_comb begin
        next_request_control = request_control;
        if (wr_pending && wr_addr == dma_channel_pkg::request_control_addr) begin
            next_request_control = {2'b00, hwdata_i[5:0]};
        end
        if (ack_i && dma_req_o) begin
            next_request_control[dma_channel_pkg::pending_bit] = 1'b0;
        end
        if (serviced && counter_zero && !swap_mode_i) begin
            next_request_control[dma_channel_pkg::request_mask_bit] = 1'b0;
        end
        if (trigger_i) begin
            next_request_control[dma_channel_pkg::pending_bit] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            request_control <= dma_channel_pkg::request_control_reset;
        end else begin
            request_control <= next_request_control;
        end
    end

    // request outputs
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            dma_req_o <= 1'b0;
            eob_irq_o <= 1'b0;
            eob_pending <= 1'b0;
            source_priority_o <= 3'h0;
        end else begin
            source_priority_o <= request_control[2:0];
            dma_req_o <= pending && request_mask && state == dma_channel_pkg::st_idle && !(ack_i && dma_req_o)
                && request_control[2:0] <= current_priority_level_i;
            if (serviced && counter_zero) begin
                eob_pending <= 1'b1;
            end else if (eob_irq_o && ack_i) begin
                eob_pending <= 1'b0;
            end
            eob_irq_o <= request_control[dma_channel_pkg::eob_mask_bit]
                && (eob_pending || (pending && !request_mask))
                && request_control[2:0] < current_priority_level_i;
        end
    end

    // transfer sequencer
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state <= dma_channel_pkg::st_idle;
            desc <= '0;
            cycle_count <= 5'd0;
            cycle_target <= 5'd0;
            move_byte <= 8'h00;
            serviced <= 1'b0;
            mem_req_o <= '0;
            desc_wr_o <= 1'b0;
            desc_wdata_o <= '0;
            desc_ptr_o <= 8'h00;
            addr_ptr_o <= 8'h00;
        end else begin
            serviced <= 1'b0;
            desc_wr_o <= 1'b0;
            desc_ptr_o <= {counter_pointer[7:1], 1'b0};
            addr_ptr_o <= {address_pointer[7:1], 1'b0};
            if (state != dma_channel_pkg::st_idle) begin
                cycle_count <= cycle_count + 5'd1;
            end
            unique case (state)
                dma_channel_pkg::st_idle: begin
                    cycle_count <= 5'd0;
                    if (dma_req_o && ack_i) begin
                        desc <= desc_i;
                        cycle_target <= counter_pointer[dma_channel_pkg::target_space_bit]
                            ? 5'(dma_channel_pkg::regfile_cycles - 1)
                            : 5'(dma_channel_pkg::memory_cycles - 1);
                        move_byte <= periph_data_i;
                        state <= dma_channel_pkg::st_read;
                    end
                end
                dma_channel_pkg::st_read: begin
                    mem_req_o.valid <= 1'b1;
                    mem_req_o.write <= periph_to_mem_i;
                    mem_req_o.to_regfile <= counter_pointer[dma_channel_pkg::target_space_bit];
                    mem_req_o.use_dma_segment <= !counter_pointer[dma_channel_pkg::target_space_bit]
                        && address_pointer[dma_channel_pkg::segment_source_bit];
                    mem_req_o.addr <= counter_pointer[dma_channel_pkg::target_space_bit]
                        ? {8'h00, desc.addr[7:0]} : desc.addr;
                    mem_req_o.data <= move_byte;
                    state <= dma_channel_pkg::st_move;
                end
                dma_channel_pkg::st_move: begin
                    if (mem_req_o.valid && mem_ready_i && (periph_to_mem_i || buf_ready)) begin
                        mem_req_o.valid <= 1'b0;
                        if (!periph_to_mem_i) begin
                            move_byte <= mem_rdata_i;
                        end
                    end
                    if (!mem_req_o.valid && cycle_count >= cycle_target) begin
                        state <= dma_channel_pkg::st_update;
                    end
                end
                dma_channel_pkg::st_update: begin
                    desc_wr_o <= 1'b1;
                    desc_wdata_o.addr <= desc.addr + 16'h0001;
                    desc_wdata_o.count <= desc.count - 16'h0001;
                    serviced <= 1'b1;
                    state <= dma_channel_pkg::st_idle;
                end
            endcase
        end
    end

    assign buf_push = state == dma_channel_pkg::st_move && mem_req_o.valid && mem_ready_i
        && !periph_to_mem_i && buf_ready;

    // buffer occupancy and read slot after this edge
    always_comb begin
        next_buf_count = buf_count + 2'(buf_push) - 2'(buf_pop);
        next_rd_ptr = buf_pop ? !buf_rd_ptr : buf_rd_ptr;
    end

    // two-entry buffer toward the peripheral
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            buf_count <= 2'd0;
            buf_wr_ptr <= 1'b0;
            buf_rd_ptr <= 1'b0;
        end else begin
            if (buf_push) begin
                buf_wr_ptr <= !buf_wr_ptr;
            end
            if (buf_pop) begin
                buf_rd_ptr <= !buf_rd_ptr;
            end
            buf_count <= next_buf_count;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (buf_push) begin
            buf_data[buf_wr_ptr] <= mem_rdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            periph_valid_o <= 1'b0;
            periph_data_o <= 8'h00;
        end else begin
            periph_valid_o <= next_buf_count != 2'd0;
            if (buf_count == 2'd0 || (buf_pop && buf_count == 2'd1)) begin
                periph_data_o <= mem_rdata_i;
            end else begin
                periph_data_o <= buf_data[next_rd_ptr];
            end
        end
    end
endmodule // dma_channel_ctrl

// ==== dma_channel_pkg.sv ====
// package: register map, field layout and timing for the dma channel control block
package dma_channel_pkg;
    // byte addresses on the register bus
    localparam logic [7:0] counter_pointer_addr = 8'h00;
    localparam logic [7:0] request_control_addr = 8'h04;
    localparam logic [7:0] address_pointer_addr = 8'h08;
    localparam logic [7:0] status_addr = 8'h0C;
    // field positions
    localparam int target_space_bit = 0;
    localparam int segment_source_bit = 0;
    localparam int pending_bit = 5;
    localparam int request_mask_bit = 4;
    localparam int eob_mask_bit = 3;
    localparam int priority_lsb = 0;
    // reset values (contents are undefined after reset; zero chosen)
    localparam logic [7:0] counter_pointer_reset = 8'h00;
    localparam logic [7:0] request_control_reset = 8'h00;
    localparam logic [7:0] address_pointer_reset = 8'h00;
    // transfer timing in core clock cycles
    localparam int regfile_cycles = 8;
    localparam int memory_cycles = 16;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_read = 2'b01,
        st_move = 2'b10,
        st_update = 2'b11
    } xfer_state_t;

    // memory-side access request
    typedef struct packed {
        logic valid;
        logic write;
        logic to_regfile;
        logic use_dma_segment;
        logic [15:0] addr;
        logic [7:0] data;
    } mem_req_t;

    // descriptor loaded from the register file
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] count;
    } descriptor_t;
endpackage

// ==== dma_channel_ctrl_monitor.sv ====
// checker: port-level properties of the dma channel control block
`timescale 1ns/1ps
module dma_channel_ctrl_monitor (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic ack_i,
    input wire logic [2:0] current_priority_level_i,
    input wire logic dma_req_o,
    input wire logic eob_irq_o,
    input wire logic [2:0] source_priority_o,
    input wire dma_channel_pkg::mem_req_t mem_req_o,
    input wire dma_channel_pkg::descriptor_t desc_i,
    input wire logic desc_wr_o,
    input wire dma_channel_pkg::descriptor_t desc_wdata_o,
    input wire logic periph_valid_o,
    input wire logic periph_ready_i
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    AST_ACK_DROPS_REQ: assert property (ack_i && dma_req_o |-> ##2 !dma_req_o)
        else $error("request still up after acknowledge");
    AST_REQ_LEVEL: assert property (dma_req_o && $stable(source_priority_o)
        && $stable(current_priority_level_i) |-> source_priority_o <= current_priority_level_i)
        else $error("request below current level");
    AST_IRQ_LEVEL: assert property (eob_irq_o && $stable(source_priority_o)
        && $stable(current_priority_level_i) |-> source_priority_o < current_priority_level_i)
        else $error("interrupt not strictly above current level");
    AST_DESC_STEP: assert property (desc_wr_o |-> desc_wdata_o.addr == desc_i.addr + 16'h0001
        && desc_wdata_o.count == desc_i.count - 16'h0001) else $error("descriptor step wrong");
    AST_ONE_UPDATE: assert property (desc_wr_o |=> !desc_wr_o)
        else $error("descriptor written twice");
    AST_XFER_SPAN: assert property (ack_i && dma_req_o |-> ##[6:80] desc_wr_o)
        else $error("transfer did not complete in time");
    AST_BUSY_NO_REQ: assert property (mem_req_o.valid |-> !dma_req_o)
        else $error("request raised during transfer");
    AST_BUF_HOLD: assert property (periph_valid_o && !periph_ready_i |=> periph_valid_o)
        else $error("buffered byte dropped");
    COV_ACK: cover property (ack_i && dma_req_o);
    COV_DONE: cover property (desc_wr_o);
    COV_EOB: cover property (eob_irq_o);
    COV_STALL: cover property (periph_valid_o && !periph_ready_i);
endmodule // dma_channel_ctrl_monitor
bind dma_channel_ctrl dma_channel_ctrl_monitor u_mon (.ref_clk_i, .reset_i, .ack_i, .current_priority_level_i,
    .dma_req_o, .eob_irq_o, .source_priority_o, .mem_req_o, .desc_i, .desc_wr_o, .desc_wdata_o,
    .periph_valid_o, .periph_ready_i);

// ==== dma_far_side.sv ====
// far-side model: descriptor store, memory port and peripheral data register
`timescale 1ns/1ps
module dma_far_side (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic slow_i,
    input wire logic stall_i,
    input wire logic load_i,
    input wire dma_channel_pkg::descriptor_t load_desc_i,
    input wire dma_channel_pkg::mem_req_t mem_req_i,
    input wire logic desc_wr_i,
    input wire dma_channel_pkg::descriptor_t desc_wdata_i,
    input wire logic periph_valid_i,
    input wire logic [7:0] periph_data_i,
    output logic mem_ready_o,
    output logic [7:0] mem_rdata_o,
    output dma_channel_pkg::descriptor_t desc_o,
    output logic periph_ready_o,
    output dma_channel_pkg::mem_req_t last_req_o,
    output logic [7:0] last_byte_o,
    output logic [7:0] byte_count_o
);
    logic [1:0] wait_cnt;
    // slow mode adds three wait cycles
    assign mem_ready_o = mem_req_i.valid && (!slow_i || wait_cnt == 2'h3);
    // data outside an accepted read follows wait_cnt, so it only moves during slow-mode wait cycles
    assign mem_rdata_o = mem_ready_o ? mem_req_i.addr[7:0] ^ 8'hA5 : {4{wait_cnt}};
    assign periph_ready_o = !stall_i;
    always_ff @(posedge ref_clk_i) begin
        wait_cnt <= (reset_i || mem_ready_o || !mem_req_i.valid) ? 2'h0 : wait_cnt + 2'h1;
        if (load_i) begin
            desc_o <= load_desc_i;
        end else if (desc_wr_i) begin
            desc_o <= desc_wdata_i;
        end
        if (mem_ready_o) begin
            last_req_o <= mem_req_i;
        end
        if (reset_i) begin
            byte_count_o <= 8'h00;
        end else if (periph_valid_i && periph_ready_o) begin
            byte_count_o <= byte_count_o + 8'h01;
            last_byte_o <= periph_data_i;
        end
    end
endmodule // dma_far_side

// ==== peripheral_dma_channel_control_test.sv ====
// self-checking testbench for the dma channel control block
`timescale 1ns/1ps
module peripheral_dma_channel_control_test;
    logic clk = 0, reset = 1, trig = 0, swap = 0, ack = 0, p2m = 0, slow = 0, stall = 0, load = 0, hw = 0;
    logic [1:0] htr = 0;
    logic [2:0] current_priority_level = 7, sprio;
    logic [7:0] pdata = 0, mrd, dptr, aptr, pbyte, lbyte, nbytes;
    logic [31:0] haddr = 0, hwd = 0, hrd, rd;
    logic hrdy, hresp, req, eob, dwr, mrdy, pval, prdy;
    dma_channel_pkg::mem_req_t mreq, lreq;
    dma_channel_pkg::descriptor_t desc, ldesc = 0, wdesc;
    int failures = 0, total_checks = 0;
    always #25 clk = ~clk;
    dma_channel_ctrl u_dut (.ref_clk_i(clk), .reset_i(reset), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htr),
        .hwrite_i(hw), .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(hrdy), .hrdata_o(hrd), .hreadyout_o(hrdy),
        .hresp_o(hresp), .trigger_i(trig), .swap_mode_i(swap), .current_priority_level_i(current_priority_level), .ack_i(ack),
        .periph_data_i(pdata), .periph_to_mem_i(p2m), .dma_req_o(req), .eob_irq_o(eob), .source_priority_o(sprio),
        .mem_req_o(mreq), .mem_ready_i(mrdy), .mem_rdata_i(mrd), .desc_i(desc), .desc_ptr_o(dptr),
        .addr_ptr_o(aptr), .desc_wr_o(dwr), .desc_wdata_o(wdesc), .periph_data_o(pbyte), .periph_valid_o(pval),
        .periph_ready_i(prdy));
    dma_far_side u_far (.ref_clk_i(clk), .reset_i(reset), .slow_i(slow), .stall_i(stall), .load_i(load),
        .load_desc_i(ldesc), .mem_req_i(mreq), .desc_wr_i(dwr), .desc_wdata_i(wdesc), .periph_valid_i(pval),
        .periph_data_i(pbyte), .mem_ready_o(mrdy), .mem_rdata_o(mrd), .desc_o(desc), .periph_ready_o(prdy),
        .last_req_o(lreq), .last_byte_o(lbyte), .byte_count_o(nbytes));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
        htr <= 2'h2;
        haddr <= {24'h0, a};
        hw <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htr <= 2'h0;
        hwd <= {24'h0, wd};
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrd;
    endtask
    task automatic xfer(input logic [7:0] cp, input logic [7:0] ap, input logic [15:0] cnt, input logic keep);
        ldesc <= {16'h0040, cnt};
        load <= 1'b1;
        current_priority_level <= 3'h0;
        swap <= keep;
        bus(1'b1, dma_channel_pkg::counter_pointer_addr, cp);
        load <= 1'b0;
        bus(1'b1, dma_channel_pkg::address_pointer_addr, ap);
        bus(1'b1, dma_channel_pkg::request_control_addr, 8'h10);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        for (int i = 0; i < 50 && req !== 1'b1; i++) @(posedge clk);
        chk("request", 1, req);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        for (int i = 0; i < 200 && dwr !== 1'b1; i++) @(posedge clk);
        chk("descriptor", {16'h0041, cnt - 16'h1}, wdesc);
        chk("target", cp[0], lreq.to_regfile);
        if (!cp[0]) chk("segment", ap[0], lreq.use_dma_segment);
        repeat (2) @(posedge clk);
        chk("served request", 0, req);
        bus(1'b0, dma_channel_pkg::request_control_addr, 8'h00);
        chk("control after block", (cnt != 16'h1 || keep) ? 8'h10 : 8'h00, rd);
    endtask
    task automatic t_regs;
        logic [7:0] v[3] = '{8'h2B, 8'h07, 8'h31};
        for (int i = 0; i < 3; i++) bus(1'b1, 8'(4 * i), v[i]);
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, 8'(4 * i), 8'h00);
            chk("readback", v[i], rd);
        end
        bus(1'b0, 8'h10, 8'h00);
        chk("unmapped", 0, rd);
        chk("response", 0, hresp);
        chk("pointers", 16'h2A30, {dptr, aptr});
        $display("test registers done");
    endtask
    task automatic t_masks;
        for (int m = 3; m >= 0; m--) begin
            bus(1'b1, dma_channel_pkg::request_control_addr, 8'h20 | 8'(m << 3));
            repeat (3) @(posedge clk);
            chk("request", m >> 1, req);
            chk("end of block", m == 1, eob);
        end
        bus(1'b1, dma_channel_pkg::request_control_addr, 8'h30);
        bus(1'b1, dma_channel_pkg::request_control_addr, 8'h10);
        repeat (3) @(posedge clk);
        chk("cancelled", 0, req);
        $display("test masks done");
    endtask
    task automatic t_prio;
        bus(1'b1, dma_channel_pkg::request_control_addr, 8'h33);
        for (int c = 2; c < 5; c++) begin
            current_priority_level <= 3'(c);
            repeat (3) @(posedge clk);
            chk("request at level", c >= 3, req);
            chk("priority", 3, sprio);
        end
        $display("test priority done");
    endtask
    task automatic t_regfile;
        p2m <= 1'b1;
        pdata <= 8'h96;
        xfer(8'h2B, 8'h31, 16'h0005, 1'b0);
        chk("moved write", {1'b1, 16'h0040, 8'h96}, {lreq.write, lreq.addr, lreq.data});
        $display("test register file done");
    endtask
    task automatic t_memory;
        p2m <= 1'b0;
        stall <= 1'b1;
        slow <= 1'b1;
        xfer(8'h2A, 8'h31, 16'h0001, 1'b0);
        chk("bytes while stalled", 0, nbytes);
        stall <= 1'b0;
        for (int i = 0; i < 20 && nbytes !== 8'h01; i++) @(posedge clk);
        chk("delivered byte", {8'h01, 8'h40 ^ 8'hA5}, {nbytes, lbyte});
        bus(1'b0, dma_channel_pkg::status_addr, 8'h00);
        chk("status", 32'h0000_0004, rd);
        $display("test memory done");
    endtask
    task automatic t_swap;
        slow <= 1'b0;
        xfer(8'h2B, 8'h30, 16'h0001, 1'b1);
        $display("test swap done");
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_regs;
        t_masks;
        t_prio;
        t_regfile;
        t_memory;
        t_swap;
        end_of_test;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_of_test;
    end
endmodule // peripheral_dma_channel_control_test
